// [rtl/canopen_node_fault_diagnostics.sv]
// per-node fault diagnostic register store with interrupt
// What this block does
// - A wrong-length transmit PDO from a node sets its process-data fault to 1.
// - A late synchronous transmit PDO sets the process-data fault to 2.
// - A node that moved on its own to pre-operational sets the process-data fault to 3.
// - A transmit PDO missing its event timer sets the process-data fault to 4.
// - Lost guarding reply or stopped heartbeat sets the process-data fault to 5.
// - A guarding toggle bit that fails to alternate sets the process-data fault to 6.
// - A node that moved on its own to stopped sets the process-data fault to 7.
// - An unrecognised node_network_state value sets the process-data fault to 8.
// - Overflow of our own transmit queue sets the process-data fault to 9.
// - Startup fault low seven bits hold cause 1 mismatch, 2 bad length, 4 bad boot-up.
// - An aborted boot_config_transfer writes startup cause 3.
// - Startup fault bit 7 is 0 for an upload failure and 1 for a download failure.
// - A boot_config_transfer abort captures the addressed object in a 32-bit entry.
// - The latest abort code of a boot_config_transfer overwrites the 32-bit abort entry.
// - A failed value check captures read and expected values in two 32-bit entries.
`timescale 1ns/1ps
module canopen_node_fault_diagnostics
	import node_fault_pkg::*;
#(
	parameter int NODES = NODE_COUNT
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire pdo_event_t pdoEvent,
	input wire startup_event_t startupEvent,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regReadData,
	output logic irq
);
	logic [15:0] pdoFault [NODES];
	logic [15:0] startupFault [NODES];
	logic [31:0] failObject [NODES];
	logic [31:0] abortCode [NODES];
	logic [31:0] valueRead [NODES];
	logic [31:0] valueExpected [NODES];
	logic [3:0] irqStatus;
	logic [3:0] irqMask;
	logic [3:0] next_irqStatus;
	logic pdoHit;
	logic suHit;
	logic abortHit;
	logic checkHit;
	logic clearHit;

	function automatic logic nodeInRange(input logic [NODE_W-1:0] n);
		nodeInRange = 32'(n) < NODES;
	endfunction : nodeInRange

	assign pdoHit = pdoEvent.valid && pdoEvent.code != PDO_NONE && nodeInRange(pdoEvent.node);
	assign suHit = startupEvent.valid && startupEvent.cause != SU_NONE
		&& nodeInRange(startupEvent.node);
	assign abortHit = suHit && startupEvent.cause == SU_TRANSFER_ABORT;
	assign checkHit = suHit && startupEvent.cause == SU_VALUE_MISMATCH;
	// software clears a node's process-data and startup fault codes by writing its number with bit 31 set
	assign clearHit = regWrite && regAddr == ADDR_CLEAR && regWriteData[31];

	// process-data fault code, codes 1..9 written straight from the event
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NODES; i++) begin
				pdoFault[i] <= FAULT_RESET;
			end
		end else begin
			if (clearHit) begin
				pdoFault[regWriteData[NODE_W-1:0]] <= FAULT_RESET;
			end
			if (pdoHit) begin
				pdoFault[pdoEvent.node] <= {12'h000, pdoEvent.code};
			end
		end
	end

	// startup fault: cause in low bits, direction in bit 7
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NODES; i++) begin
				startupFault[i] <= FAULT_RESET;
			end
		end else begin
			if (clearHit) begin
				startupFault[regWriteData[NODE_W-1:0]] <= FAULT_RESET;
			end
			if (suHit) begin
				startupFault[startupEvent.node] <= {8'h00, startupEvent.download,
					startupEvent.cause};
			end
		end
	end

	// abort details: object and abort code
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NODES; i++) begin
				failObject[i] <= WORD_RESET;
				abortCode[i] <= WORD_RESET;
			end
		end else if (abortHit) begin
			failObject[startupEvent.node] <= startupEvent.object;
			abortCode[startupEvent.node] <= startupEvent.abortCode;
		end
	end

	// value check details
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NODES; i++) begin
				valueRead[i] <= WORD_RESET;
				valueExpected[i] <= WORD_RESET;
			end
		end else if (checkHit) begin
			valueRead[startupEvent.node] <= startupEvent.valueRead;
			valueExpected[startupEvent.node] <= startupEvent.valueExpected;
		end
	end

	// sticky status: bit0 pdo fault, bit1 startup fault, bit2 abort, bit3 check fail
	always_comb begin
		next_irqStatus = irqStatus;
		if (regWrite && regAddr == ADDR_IRQ_STATUS) begin
			next_irqStatus = irqStatus & ~regWriteData[3:0];
		end
		// set wins over clear
		next_irqStatus = next_irqStatus | {checkHit, abortHit, suHit, pdoHit};
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqStatus <= 4'h0;
		end else begin
			irqStatus <= next_irqStatus;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqMask <= MASK_RESET;
		end else if (regWrite && regAddr == ADDR_IRQ_MASK) begin
			irqMask <= regWriteData[3:0];
		end
	end

	assign irq = |(irqStatus & irqMask);

	// read port, data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			regReadData <= WORD_RESET;
		end else if (regRead) begin
			regReadData <= WORD_RESET;
			if (regAddr == ADDR_IRQ_STATUS) begin
				regReadData <= {28'h0000000, irqStatus};
			end else if (regAddr == ADDR_IRQ_MASK) begin
				regReadData <= {28'h0000000, irqMask};
			end else if (!regAddr[7] && regAddr[1:0] == 2'h0
					&& nodeInRange(regAddr[5+NODE_W-1:5])) begin
				case (regAddr[4:2])
					IDX_PDO_FAULT: regReadData <= {16'h0000, pdoFault[regAddr[5+NODE_W-1:5]]};
					IDX_STARTUP_FAULT: regReadData <= {16'h0000,
						startupFault[regAddr[5+NODE_W-1:5]]};
					IDX_FAIL_OBJECT: regReadData <= failObject[regAddr[5+NODE_W-1:5]];
					IDX_ABORT_CODE: regReadData <= abortCode[regAddr[5+NODE_W-1:5]];
					IDX_VALUE_READ: regReadData <= valueRead[regAddr[5+NODE_W-1:5]];
					IDX_VALUE_EXPECTED: regReadData <= valueExpected[regAddr[5+NODE_W-1:5]];
					default: regReadData <= WORD_RESET;
				endcase
			end
		end
	end
endmodule : canopen_node_fault_diagnostics

// [rtl/node_fault_pkg.sv]
// shared constants and types for the per-node fault diagnostics store
package node_fault_pkg;
	localparam int NODE_COUNT = 4;
	localparam int NODE_W = 2;
	localparam int ADDR_W = 8;
	// register word index within a node block, byte address = node*32 + word*4
	localparam logic [2:0] IDX_PDO_FAULT = 3'h0;
	localparam logic [2:0] IDX_STARTUP_FAULT = 3'h1;
	localparam logic [2:0] IDX_FAIL_OBJECT = 3'h2;
	localparam logic [2:0] IDX_ABORT_CODE = 3'h3;
	localparam logic [2:0] IDX_VALUE_READ = 3'h4;
	localparam logic [2:0] IDX_VALUE_EXPECTED = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h80;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h84;
	localparam logic [ADDR_W-1:0] ADDR_CLEAR = 8'h88;
	localparam logic [15:0] FAULT_RESET = 16'h0000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// startup fault field layout
	localparam int STARTUP_DIR_BIT = 7;
	localparam int STARTUP_CAUSE_W = 7;

	typedef enum logic [3:0] {
		PDO_NONE = 4'h0,
		PDO_BAD_LENGTH = 4'h1,
		PDO_SYNC_LATE = 4'h2,
		PDO_TO_PREOP = 4'h3,
		PDO_EVENT_LATE = 4'h4,
		PDO_GUARD_LOST = 4'h5,
		PDO_TOGGLE_STUCK = 4'h6,
		PDO_TO_STOPPED = 4'h7,
		PDO_UNKNOWN_STATE = 4'h8,
		PDO_TX_OVERFLOW = 4'h9
	} pdo_fault_t;

	typedef enum logic [6:0] {
		SU_NONE = 7'h00,
		SU_VALUE_MISMATCH = 7'h01,
		SU_BAD_LENGTH = 7'h02,
		SU_TRANSFER_ABORT = 7'h03,
		SU_BAD_BOOTUP = 7'h04
	} startup_cause_t;

	// one reported process-data event
	typedef struct packed {
		logic valid;
		logic [NODE_W-1:0] node;
		pdo_fault_t code;
	} pdo_event_t;

	// one reported boot_config_transfer failure
	typedef struct packed {
		logic valid;
		logic [NODE_W-1:0] node;
		startup_cause_t cause;
		logic download;
		logic [31:0] object;
		logic [31:0] abortCode;
		logic [31:0] valueRead;
		logic [31:0] valueExpected;
	} startup_event_t;
endpackage : node_fault_pkg

// [dv/node_fault_monitor.sv]
// port checker for the node fault store
`timescale 1ns/1ps
module node_fault_monitor
	import node_fault_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire pdo_event_t pdoEvent,
	input wire startup_event_t startupEvent,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regReadData,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	pdo_event_t pe;
	startup_event_t se;
	logic [7:0] sb;
	logic pr, sr;
	always_ff @(posedge clk_sys) begin
		pe <= pdoEvent;
		se <= startupEvent;
	end
	// read of an entry right after its event
	assign pr = regRead && pe.valid && pe.code != PDO_NONE && regAddr == {1'b0, pe.node, 5'h00};
	assign sb = {1'b0, se.node, 5'h00};
	assign sr = regRead && se.valid && se.cause != SU_NONE;
	AST_PDO: assert property (pr |=> regReadData[3:0] == $past(pe.code))
		else $error("pdo code wrong");
	AST_SU: assert property (sr && regAddr == sb + 8'h04
		|=> regReadData == {24'h0, $past(se.download), $past(se.cause)}) else $error("su code wrong");
	AST_OBJ: assert property (sr && se.cause == SU_TRANSFER_ABORT && regAddr == sb + 8'h08
		|=> regReadData == $past(se.object)) else $error("object wrong");
	AST_ABORT: assert property (sr && se.cause == SU_TRANSFER_ABORT && regAddr == sb + 8'h0c
		|=> regReadData == $past(se.abortCode)) else $error("abort wrong");
	AST_VREAD: assert property (sr && se.cause == SU_VALUE_MISMATCH && regAddr == sb + 8'h10
		|=> regReadData == $past(se.valueRead)) else $error("read value wrong");
	AST_VEXP: assert property (sr && se.cause == SU_VALUE_MISMATCH && regAddr == sb + 8'h14
		|=> regReadData == $past(se.valueExpected)) else $error("expected value wrong");
	AST_UPPER: assert property (regRead && !regAddr[7] && regAddr[4:3] == 2'h0
		|=> regReadData[31:8] == 24'h0) else $error("upper bits set");
	AST_RST: assert property ($rose(rst_b) |-> regReadData == 32'h0 && !irq)
		else $error("not clear after reset");
endmodule : node_fault_monitor
bind canopen_node_fault_diagnostics node_fault_monitor mon_u(.clk_sys, .rst_b, .pdoEvent,
	.startupEvent, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .irq);

// [dv/slave_node_model.sv]
// behavioural slave nodes raising fault events
`timescale 1ns/1ps
module slave_node_model
	import node_fault_pkg::*;
(
	input wire logic clk_sys,
	output pdo_event_t pdoEvent,
	output startup_event_t startupEvent
);
	initial pdoEvent = '0;
	initial startupEvent = '0;
	// released payload is inverted so stale data is never mistaken for valid
	task automatic pdo(int n, int c);
		pdoEvent <= '{1'b1, NODE_W'(n), pdo_fault_t'(c)};
		@(posedge clk_sys) pdoEvent <= ~pdoEvent;
	endtask : pdo
	task automatic su(int n, int c, int d, logic [31:0] o, a, v, x);
		startupEvent <= '{1'b1, NODE_W'(n), startup_cause_t'(c), d[0], o, a, v, x};
		@(posedge clk_sys) startupEvent <= ~startupEvent;
	endtask : su
endmodule : slave_node_model

// [dv/canopen_node_fault_diagnostics_tb.sv]
// self-checking bench for the node fault store
`timescale 1ns/1ps
module canopen_node_fault_diagnostics_tb;
	import node_fault_pkg::*;
	logic clk_sys, irq, rst_b = 0, regWrite = 0, regRead = 0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [31:0] regWriteData = '0, regReadData, o, a, v, x;
	pdo_event_t pdoEvent;
	startup_event_t startupEvent;
	int n_mismatch = 0, n_checks = 0, n, d;
	int m[4][6] = '{default: 0};
	int cs[7] = '{1, 2, 3, 4, 3, 3, 1};
	int fo[7] = '{16, 4, 8, 4, 12, 12, 20};
	canopen_node_fault_diagnostics dut_u(.clk_sys, .rst_b, .pdoEvent, .startupEvent,
		.regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .irq);
	slave_node_model node_u(.clk_sys, .pdoEvent, .startupEvent);
	task automatic chk(logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic rd(logic [7:0] ad, logic [31:0] e);
		regRead <= 1'b1;
		regAddr <= ad;
		@(posedge clk_sys) regRead <= 1'b0;
		@(negedge clk_sys) chk(regReadData, e);
		@(posedge clk_sys);
	endtask : rd
	task automatic wr(logic [7:0] ad, logic [31:0] dt);
		regWrite <= 1'b1;
		regAddr <= ad;
		regWriteData <= dt;
		@(posedge clk_sys) regWrite <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd_node(int k);
		for (int w = 0; w < 6; w++) rd(8'(k * 32 + w * 4), m[k][w]);
	endtask : rd_node
	task automatic ck_irq(logic e);
		@(negedge clk_sys) chk({31'h0, irq}, {31'h0, e});
		@(posedge clk_sys);
	endtask : ck_irq
	task automatic end_sim();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		void'($urandom(32'h5873415a));
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++) rd_node(i);
		rd(8'h84, 0);
		for (int c = 0; c < 10; c++) begin
			n = $urandom_range(3);
			node_u.pdo(n, c);
			if (c != 0) m[n][0] = c;
			rd(8'(n * 32), m[n][0]);
		end
		foreach (cs[i]) begin
			n = $urandom_range(3);
			d = $urandom_range(1);
			o = $urandom;
			a = $urandom;
			v = $urandom;
			x = $urandom;
			node_u.su(n, cs[i], d, o, a, v, x);
			m[n][1] = d * 128 + cs[i];
			if (cs[i] == 3) m[n][2] = o;
			if (cs[i] == 3) m[n][3] = a;
			if (cs[i] == 1) m[n][4] = v;
			if (cs[i] == 1) m[n][5] = x;
			rd(8'(n * 32 + fo[i]), m[n][fo[i] / 4]);
			rd_node(n);
		end
		// entries are read only, then node 1 is cleared
		wr(8'h20, $urandom);
		wr(8'h88, 32'h8000_0001);
		m[1][0] = 0;
		m[1][1] = 0;
		rd_node(1);
		rd(8'ha0, 0);
		wr(8'h80, 32'hf);
		rd(8'h80, 0);
		wr(8'h84, 32'h1);
		node_u.pdo(2, 6);
		ck_irq(1);
		rd(8'h80, 1);
		wr(8'h80, 32'h1);
		ck_irq(0);
		wr(8'h84, 32'h2);
		node_u.pdo(3, 9);
		ck_irq(0);
		o = $urandom;
		node_u.su(0, 3, 1, o, o, o, o);
		wr(8'h84, 32'h4);
		ck_irq(1);
		rd(8'h80, 32'h7);
		rd(8'h84, 32'h4);
		end_sim();
	end
endmodule : canopen_node_fault_diagnostics_tb
